// file: ext_mem_port.sv
// external data memory port: address mapping, pin sequencing, on-chip ram
//
// Summary of operation
// R1: pins owned only during off-chip move
// R2: input pins have drivers turned off
// R3: output driver type follows port configuration
// R4: data and low address share lines
// R5: banked or wide access drives upper nibble
// R6: latch phase then data phase
// R7: device makes latch strobe for external latch
// R8: mode 00 keeps every access on-chip
// R9: on-chip addresses wrap within ram
// R10: page plus index, or wide pointer
// R11: split modes route by ram boundary
// R12: flat split leaves upper nibble undriven for narrow access
// R13: wide access drives all twelve bits
// R14: banked split drives page nibble
// R15: mode 11 sends everything off-chip
// R16: external mode ignores page for narrow
// R17: access is programmed cycles plus four
// R18: latch strobe adds at least two cycles
// R19: each timing width programmable in cycles
// R20: setup and hold reset to maximum
// R21: software parks port latches idle high
// R22: software keeps strobe pins off crossbar
// R23: latch width code gives 1 to 4
// R24: page msb sends narrow access off-chip
// R25: on-chip ram holds 4096 bytes
// R26: strobes active low, high after access
// R27: processor stalls until access completes
`timescale 1ns/1ps
`default_nettype none

module ext_mem_port #(
  parameter int RAM_BYTES = ext_mem_pkg::ONCHIP_BYTES
) (
  // clock and reset
  input  wire logic                     I_CLK,
  input  wire logic                     I_NRST,
  // register port
  input  wire logic [7:0]               i_REG_ADDR,
  input  wire logic [7:0]               i_REG_WDATA,
  input  wire logic                     i_REG_WR,
  input  wire logic                     i_REG_RD,
  output var  logic [7:0]               o_REG_RDATA,
  // processor move access
  input  wire logic                     i_ACC_VALID,
  input  wire ext_mem_pkg::acc_req_type i_ACC,
  output logic                          o_ACC_STALL,
  output var  logic                     o_ACC_DONE,
  output var  logic [7:0]               o_ACC_RDATA,
  // port latches and pins
  input  wire logic [14:0]              i_LATCH_VAL,
  input  wire logic [14:0]              i_LATCH_OE_N,
  input  wire logic [14:0]              i_PIN_IN,
  output logic [14:0]                   o_PIN_OUT,
  output logic [14:0]                   o_PIN_OE_N,
  output logic [14:0]                   o_PIN_OWNED
);

  // ==========================================================
  // state
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LATCH_HI,
    ST_LATCH_LO,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD,
    ST_ONCHIP,
    ST_FINISH
  } state_type;

  state_type                          state;
  state_type                          next_state;
  logic [3:0]                         cnt;
  logic [3:0]                         next_cnt;

  // registers
  logic [4:0]                         ext_data_ram_page_reg;
  ext_mem_pkg::mode_select_field_type mode;
  logic [1:0]                         latch_width;
  logic [7:0]                         ext_mem_timing_reg;

  // latched request
  logic                               req_write;
  logic [15:0]                        req_addr;
  logic [7:0]                         req_wdata;
  logic                               drive_high;
  logic                               last_off;

  // decode
  logic [15:0]                        eff_addr;
  logic                               go_off;
  logic                               hi_drive;
  logic [1:0]                         setup_field;
  logic [3:0]                         strobe_field;
  logic [1:0]                         hold_field;
  logic [3:0]                         latch_cycles;
  logic                               accept;

  // ram
  logic [7:0]                         ram_q;
  logic                               ram_wr;

  // pins
  logic                               owned;
  logic [14:0]                        bus_val;
  logic [14:0]                        own_mask;
  logic [14:0]                        in_mask;

  // ==========================================================
  // register port
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      ext_data_ram_page_reg      <= ext_mem_pkg::PAGE_RESET;
      mode               <= ext_mem_pkg::MODE_INTERNAL;
      latch_width        <= ext_mem_pkg::LATCH_W_RESET;
      ext_mem_timing_reg <= ext_mem_pkg::TIMING_RESET; // R20
    end else if (i_REG_WR) begin
      if (i_REG_ADDR == ext_mem_pkg::PAGE_OFFSET) begin
        ext_data_ram_page_reg <= i_REG_WDATA[ext_mem_pkg::PAGE_POS +: 5];
      end else if (i_REG_ADDR == ext_mem_pkg::CONFIG_OFFSET) begin
        mode <= ext_mem_pkg::mode_select_field_type'(
                  i_REG_WDATA[ext_mem_pkg::MODE_POS +: 2]);
        latch_width <= i_REG_WDATA[ext_mem_pkg::LATCH_W_POS +: 2];
      end else if (i_REG_ADDR == ext_mem_pkg::TIMING_OFFSET) begin
        ext_mem_timing_reg <= i_REG_WDATA; // R19
      end
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      o_REG_RDATA <= 8'h00;
    end else if (i_REG_RD) begin
      if (i_REG_ADDR == ext_mem_pkg::PAGE_OFFSET) begin
        o_REG_RDATA <= {3'h0, ext_data_ram_page_reg};
      end else if (i_REG_ADDR == ext_mem_pkg::CONFIG_OFFSET) begin
        o_REG_RDATA <= {4'h0, mode, latch_width};
      end else if (i_REG_ADDR == ext_mem_pkg::TIMING_OFFSET) begin
        o_REG_RDATA <= ext_mem_timing_reg;
      end else if (i_REG_ADDR == ext_mem_pkg::STATUS_OFFSET) begin
        o_REG_RDATA <= {6'h00, last_off, state != ST_IDLE};
      end else begin
        o_REG_RDATA <= 8'h00;
      end
    end else begin
      o_REG_RDATA <= 8'h00;
    end
  end

  // ==========================================================
  // address decode
  assign setup_field  = ext_mem_timing_reg[ext_mem_pkg::SETUP_POS +: 2];
  assign strobe_field = ext_mem_timing_reg[ext_mem_pkg::STROBE_POS +: 4];
  assign hold_field   = ext_mem_timing_reg[ext_mem_pkg::HOLD_POS +: 2];
  assign latch_cycles = {2'h0, latch_width}; // R23

  always_comb begin
    // narrow form: page high byte, index low byte
    if (i_ACC.wide) begin
      eff_addr = i_ACC.pointer; // R10
    end else begin
      eff_addr = {3'h0, ext_data_ram_page_reg, i_ACC.index}; // R10
    end
    go_off   = 1'b0;
    hi_drive = 1'b0;
    case (mode)
      ext_mem_pkg::MODE_INTERNAL: begin
        go_off = 1'b0; // R8
      end
      ext_mem_pkg::MODE_SPLIT_FLAT: begin
        if (i_ACC.wide) begin
          go_off   = i_ACC.pointer >= 16'(RAM_BYTES); // R11 R13
          hi_drive = 1'b1; // R13
        end else begin
          go_off   = ext_data_ram_page_reg[ext_mem_pkg::PAGE_WIDTH-1]; // R24
          hi_drive = 1'b0; // R12
        end
      end
      ext_mem_pkg::MODE_SPLIT_BANK: begin
        if (i_ACC.wide) begin
          go_off = i_ACC.pointer >= 16'(RAM_BYTES); // R11 R13
        end else begin
          go_off = ext_data_ram_page_reg[ext_mem_pkg::PAGE_WIDTH-1]; // R24
        end
        hi_drive = 1'b1; // R14 R13
      end
      default: begin
        go_off   = 1'b1; // R15
        hi_drive = i_ACC.wide; // R16
        if (!i_ACC.wide) begin
          eff_addr = {8'h00, i_ACC.index}; // R16
        end
      end
    endcase
  end

  assign accept = i_ACC_VALID && (state == ST_IDLE);

  // ==========================================================
  // request capture
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      req_write  <= 1'b0;
      req_addr   <= 16'h0000;
      req_wdata  <= 8'h00;
      drive_high <= 1'b0;
      last_off   <= 1'b0;
    end else if (accept) begin
      req_write  <= i_ACC.write;
      req_addr   <= eff_addr;
      req_wdata  <= i_ACC.wdata;
      drive_high <= hi_drive; // R5
      last_off   <= go_off;
    end
  end

  // ==========================================================
  // on-chip ram; the address simply drops upper bits, so it wraps
  assign ram_wr = accept && !go_off && i_ACC.write;

  ext_data_ram_array #(
    .DEPTH (RAM_BYTES),
    .AW    (ext_mem_pkg::ONCHIP_AW)
  ) u_ram (
    .i_clk   (I_CLK),
    .i_wr    (ram_wr),
    .i_addr  (eff_addr[ext_mem_pkg::ONCHIP_AW-1:0]), // R9 R25
    .i_wdata (i_ACC.wdata),
    .o_rdata (ram_q)
  );

  // ==========================================================
  // access sequencer: each phase lasts its field plus one cycle
  always_comb begin
    next_state = state;
    next_cnt   = (cnt != 4'h0) ? cnt - 4'h1 : 4'h0;
    case (state)
      ST_IDLE: begin
        if (accept) begin
          if (go_off) begin
            next_state = ST_LATCH_HI; // R6
            next_cnt   = latch_cycles; // R18
          end else begin
            next_state = ST_ONCHIP; // R8
          end
        end
      end
      ST_LATCH_HI: begin
        if (cnt == 4'h0) begin
          next_state = ST_LATCH_LO; // R6
          next_cnt   = latch_cycles; // R18
        end
      end
      ST_LATCH_LO: begin
        if (cnt == 4'h0) begin
          next_state = ST_SETUP;
          next_cnt   = {2'h0, setup_field}; // R19
        end
      end
      ST_SETUP: begin
        if (cnt == 4'h0) begin
          next_state = ST_STROBE;
          next_cnt   = strobe_field; // R19
        end
      end
      ST_STROBE: begin
        if (cnt == 4'h0) begin
          next_state = ST_HOLD;
          next_cnt   = {2'h0, hold_field}; // R19
        end
      end
      ST_HOLD: begin
        if (cnt == 4'h0) begin
          next_state = ST_FINISH; // R17
        end
      end
      ST_ONCHIP: begin
        next_state = ST_FINISH;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      state <= ST_IDLE;
      cnt   <= 4'h0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // processor waits from request until the finish cycle
  assign o_ACC_STALL = accept ||
                       (state != ST_IDLE && state != ST_FINISH); // R27

  // ==========================================================
  // returned data and completion
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      o_ACC_RDATA <= 8'h00;
    end else if (state == ST_ONCHIP && !req_write) begin
      o_ACC_RDATA <= ram_q;
    end else if (state == ST_STROBE && cnt == 4'h0 && !req_write) begin
      // sampled at the last strobe cycle, before the strobe rises
      o_ACC_RDATA <= i_PIN_IN[ext_mem_pkg::PIN_AD_LO +: 8];
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      o_ACC_DONE <= 1'b0;
    end else begin
      o_ACC_DONE <= (next_state == ST_FINISH); // R27
    end
  end

  // ==========================================================
  // pin values while owned
  // the finish cycle already belongs to the port latches
  assign owned = (state == ST_LATCH_HI) || (state == ST_LATCH_LO) ||
                 (state == ST_SETUP) || (state == ST_STROBE) ||
                 (state == ST_HOLD); // R1

  always_comb begin
    bus_val  = 15'h7fff;
    own_mask = 15'h0000;
    in_mask  = 15'h0000;
    if (owned) begin
      own_mask[ext_mem_pkg::PIN_LATCH] = 1'b1;
      own_mask[ext_mem_pkg::PIN_READ]  = 1'b1;
      own_mask[ext_mem_pkg::PIN_WRITE] = 1'b1;
      own_mask[ext_mem_pkg::PIN_AD_LO +: 8] = 8'hff;
      own_mask[ext_mem_pkg::PIN_AHI_LO +: 4] = {4{drive_high}}; // R5 R12
      bus_val[ext_mem_pkg::PIN_AHI_LO +: 4] = req_addr[11:8]; // R13 R14
      bus_val[ext_mem_pkg::PIN_LATCH] = (state == ST_LATCH_HI); // R7
      bus_val[ext_mem_pkg::PIN_READ]  =
        !(state == ST_STROBE && !req_write); // R26
      bus_val[ext_mem_pkg::PIN_WRITE] =
        !(state == ST_STROBE && req_write); // R26
      if (state == ST_LATCH_HI || state == ST_LATCH_LO) begin
        bus_val[ext_mem_pkg::PIN_AD_LO +: 8] = req_addr[7:0]; // R4
      end else if (req_write) begin
        bus_val[ext_mem_pkg::PIN_AD_LO +: 8] = req_wdata; // R4
      end else begin
        in_mask[ext_mem_pkg::PIN_AD_LO +: 8] = 8'hff; // R2
      end
    end
  end

  // ==========================================================
  // per-pin sharing with the port latches
  genvar p;
  generate
    for (p = 0; p < ext_mem_pkg::PIN_COUNT; p++) begin : g_pin
      assign o_PIN_OWNED[p] = own_mask[p]; // R1
      assign o_PIN_OUT[p]   = own_mask[p] ? bus_val[p] : i_LATCH_VAL[p];
      // never switches a driver on; only forces it off for inputs
      assign o_PIN_OE_N[p]  = (own_mask[p] && in_mask[p]) ? 1'b1 :
                              i_LATCH_OE_N[p]; // R2 R3
    end
  endgenerate

endmodule // ext_mem_port

`default_nettype wire

// file: ext_mem_pkg.sv
// shared constants and types for the external data memory port
package ext_mem_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] PAGE_OFFSET   = 8'haa;
  localparam logic [7:0] CONFIG_OFFSET = 8'hab;
  localparam logic [7:0] TIMING_OFFSET = 8'haf;
  localparam logic [7:0] STATUS_OFFSET = 8'hac;

  // ==========================================================
  // field positions and widths
  localparam int PAGE_POS     = 0;
  localparam int PAGE_WIDTH   = 5;
  localparam int MODE_POS     = 2;
  localparam int LATCH_W_POS  = 0;
  localparam int SETUP_POS    = 6;
  localparam int STROBE_POS   = 2;
  localparam int HOLD_POS     = 0;

  // ==========================================================
  // reset values
  localparam logic [4:0] PAGE_RESET    = 5'h00;
  localparam logic [1:0] MODE_RESET    = 2'h0;
  localparam logic [1:0] LATCH_W_RESET = 2'h3;
  localparam logic [7:0] TIMING_RESET  = 8'hff;

  // ==========================================================
  // memory map and pin positions
  localparam int ONCHIP_BYTES = 4096;
  localparam int ONCHIP_AW    = 12;
  localparam int PIN_COUNT    = 15;
  localparam int PIN_AD_LO    = 0;
  localparam int PIN_AHI_LO   = 8;
  localparam int PIN_LATCH    = 12;
  localparam int PIN_READ     = 13;
  localparam int PIN_WRITE    = 14;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    MODE_INTERNAL   = 2'h0,
    MODE_SPLIT_FLAT = 2'h1,
    MODE_SPLIT_BANK = 2'h2,
    MODE_EXTERNAL   = 2'h3
  } mode_select_field_type;

  typedef struct packed {
    logic        write;
    logic        wide;
    logic [7:0]  index;
    logic [15:0] pointer;
    logic [7:0]  wdata;
  } acc_req_type;

endpackage : ext_mem_pkg

// file: ext_data_ram_array.sv
// on-chip data ram with registered read port
`timescale 1ns/1ps
`default_nettype none

module ext_data_ram_array #(
  parameter int DEPTH = 4096,
  parameter int AW    = 12
) (
  // clock
  input  wire logic          i_clk,
  // access
  input  wire logic          i_wr,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [7:0]    i_wdata,
  output var  logic [7:0]    o_rdata
);

  // ==========================================================
  // storage
  logic [7:0] mem [DEPTH];

  // read-during-write returns old contents; no reset on the array
  always_ff @(posedge i_clk) begin
    if (i_wr) begin
      mem[i_addr] <= i_wdata;
    end
    o_rdata <= mem[i_addr];
  end

endmodule // ext_data_ram_array

`default_nettype wire

// file: ext_mem_port_props.sv
// assertion checker for the external data memory port
`timescale 1ns/1ps
`default_nettype none

module ext_mem_port_props (
  // clock and reset
  input wire logic                     I_CLK,
  input wire logic                     I_NRST,
  // register port
  input wire logic [7:0]               i_REG_ADDR,
  input wire logic [7:0]               i_REG_WDATA,
  input wire logic                     i_REG_WR,
  input wire logic                     i_REG_RD,
  input wire logic [7:0]               o_REG_RDATA,
  // move access
  input wire logic                     i_ACC_VALID,
  input wire ext_mem_pkg::acc_req_type i_ACC,
  input wire logic                     o_ACC_STALL,
  input wire logic                     o_ACC_DONE,
  input wire logic [7:0]               o_ACC_RDATA,
  // pins
  input wire logic [14:0]              i_LATCH_VAL,
  input wire logic [14:0]              i_LATCH_OE_N,
  input wire logic [14:0]              i_PIN_IN,
  input wire logic [14:0]              o_PIN_OUT,
  input wire logic [14:0]              o_PIN_OE_N,
  input wire logic [14:0]              o_PIN_OWNED
);
  // ==========================================================
  // helper state: the request fields stand for one cycle only
  logic       busy;
  logic [7:0] lo;
  logic [7:0] wd;
  logic [3:0] hi;
  logic       wq;
  logic [1:0] mq;

  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      busy <= 1'b0;
    end else if (i_ACC_VALID && !busy) begin
      busy <= 1'b1;
    end else if (o_ACC_DONE) begin
      busy <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (i_ACC_VALID && !busy) begin
      lo <= i_ACC.wide ? i_ACC.pointer[7:0] : i_ACC.index;
      wd <= i_ACC.wdata;
      hi <= i_ACC.pointer[11:8];
      wq <= i_ACC.wide;
    end
  end

  // mode field as software last wrote it
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      mq <= ext_mem_pkg::MODE_RESET;
    end else if (i_REG_WR && i_REG_ADDR == ext_mem_pkg::CONFIG_OFFSET) begin
      mq <= i_REG_WDATA[ext_mem_pkg::MODE_POS +: 2];
    end
  end

  // ==========================================================
  // properties
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);

  chk_idle_pins: assert property (
    (o_PIN_OUT & ~o_PIN_OWNED) == (i_LATCH_VAL & ~o_PIN_OWNED))
    else $error("free pin not following its latch");
  chk_owned_busy: assert property (
    o_PIN_OWNED != 15'h0000 |-> busy && !o_ACC_DONE)
    else $error("pins owned outside an access");
  chk_no_self_on: assert property (
    (i_LATCH_OE_N & ~o_PIN_OE_N) == 15'h0000 &&
    ((o_PIN_OE_N ^ i_LATCH_OE_N) & ~o_PIN_OWNED) == 15'h0000)
    else $error("driver enabled against port setting");
  chk_read_float: assert property (
    o_PIN_OWNED[13] && !o_PIN_OUT[13] |-> o_PIN_OE_N[7:0] == 8'hff)
    else $error("data driver on during read");
  chk_latch_addr: assert property (
    o_PIN_OWNED[12] && o_PIN_OUT[12] |-> o_PIN_OUT[7:0] == lo)
    else $error("low address missing in latch phase");
  chk_write_data: assert property (
    o_PIN_OWNED[14] && !o_PIN_OUT[14] |->
    o_PIN_OUT[7:0] == wd && !o_PIN_OUT[12])
    else $error("write data not on shared lines");
  chk_nibble_whole: assert property (
    o_PIN_OWNED[12] |->
    o_PIN_OWNED[11:8] == 4'h0 || o_PIN_OWNED[11:8] == 4'hf)
    else $error("upper address pins split");
  chk_wide_nibble: assert property (
    o_PIN_OWNED[12] && wq |->
    o_PIN_OWNED[11:8] == 4'hf && o_PIN_OUT[11:8] == hi)
    else $error("wide access upper address not driven");
  chk_narrow_nibble: assert property (
    o_PIN_OWNED[12] && !wq |->
    o_PIN_OWNED[11:8] == ((mq == 2'h2) ? 4'hf : 4'h0))
    else $error("narrow access upper address ownership wrong");
  chk_min_access: assert property (
    $rose(o_PIN_OWNED[12]) |-> !o_ACC_DONE [*5])
    else $error("off-chip access too short");
  chk_strobe_end: assert property (
    o_ACC_DONE |-> o_PIN_OWNED == 15'h0000 &&
    $past(o_PIN_OUT[14:13]) == 2'b11)
    else $error("strobe low at end of access");
  chk_stall_done: assert property (
    $fell(o_ACC_STALL) |-> o_ACC_DONE)
    else $error("stall ended without completion");
endmodule // ext_mem_port_props

bind ext_mem_port ext_mem_port_props chk (
  .I_CLK(I_CLK), .I_NRST(I_NRST), .i_REG_ADDR(i_REG_ADDR),
  .i_REG_WDATA(i_REG_WDATA), .i_REG_WR(i_REG_WR), .i_REG_RD(i_REG_RD),
  .o_REG_RDATA(o_REG_RDATA), .i_ACC_VALID(i_ACC_VALID), .i_ACC(i_ACC),
  .o_ACC_STALL(o_ACC_STALL), .o_ACC_DONE(o_ACC_DONE),
  .o_ACC_RDATA(o_ACC_RDATA), .i_LATCH_VAL(i_LATCH_VAL),
  .i_LATCH_OE_N(i_LATCH_OE_N), .i_PIN_IN(i_PIN_IN),
  .o_PIN_OUT(o_PIN_OUT), .o_PIN_OE_N(o_PIN_OE_N),
  .o_PIN_OWNED(o_PIN_OWNED));

`default_nettype wire

// file: ext_sram_model.sv
// off-chip sram behind a transparent address latch, lines pulled up
`timescale 1ns/1ps
`default_nettype none

module ext_sram_model (
  // clock
  input  wire logic        i_clk,
  // pins
  input  wire logic [14:0] i_pin_out,
  input  wire logic [14:0] i_pin_oe_n,
  output logic      [14:0] o_pin_wire
);
  // ==========================================================
  // storage and address latch
  logic [7:0]  mem [0:4095];
  logic [7:0]  lat;
  logic [14:0] drv;
  logic [11:0] addr;

  // undriven lines float to the pull-up level, never the last value
  assign drv  = i_pin_out | i_pin_oe_n;
  assign addr = {drv[11:8], lat};
  // sram drives data only while read strobe is low
  assign o_pin_wire = {drv[14:8], drv[13] ? drv[7:0] : mem[addr]};

  // transparent while the strobe is high, holds once it falls
  always_latch begin
    if (drv[12]) begin
      lat = drv[7:0];
    end
  end

  // strobe pins parked high by their latches between accesses
  always_ff @(posedge i_clk) begin
    if (!drv[14]) begin
      mem[addr] <= drv[7:0];
    end
  end
endmodule // ext_sram_model

`default_nettype wire

// file: tb_top.sv
// self-checking bench for the external data memory port
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic I_CLK, I_NRST, i_REG_WR, i_REG_RD, i_ACC_VALID;
  logic [7:0] i_REG_ADDR, i_REG_WDATA, o_REG_RDATA, o_ACC_RDATA;
  logic o_ACC_STALL, o_ACC_DONE;
  ext_mem_pkg::acc_req_type i_ACC;
  logic [14:0] i_LATCH_VAL, i_LATCH_OE_N, i_PIN_IN;
  logic [14:0] o_PIN_OUT, o_PIN_OE_N, o_PIN_OWNED;
  int failures, n_tests, cnt;
  logic [16:0] aq [$];
  logic [7:0] rq [$];
  logic [16:0] x;
  logic pend;
  logic [7:0] cfg, tim, d0, d1, d2;
  logic [14:0] oe;

  ext_mem_port dut (.I_CLK(I_CLK), .I_NRST(I_NRST),
    .i_REG_ADDR(i_REG_ADDR), .i_REG_WDATA(i_REG_WDATA),
    .i_REG_WR(i_REG_WR), .i_REG_RD(i_REG_RD), .o_REG_RDATA(o_REG_RDATA),
    .i_ACC_VALID(i_ACC_VALID), .i_ACC(i_ACC), .o_ACC_STALL(o_ACC_STALL),
    .o_ACC_DONE(o_ACC_DONE), .o_ACC_RDATA(o_ACC_RDATA),
    .i_LATCH_VAL(i_LATCH_VAL), .i_LATCH_OE_N(i_LATCH_OE_N),
    .i_PIN_IN(i_PIN_IN), .o_PIN_OUT(o_PIN_OUT),
    .o_PIN_OE_N(o_PIN_OE_N), .o_PIN_OWNED(o_PIN_OWNED));
  ext_sram_model sram (.i_clk(I_CLK), .i_pin_out(o_PIN_OUT),
    .i_pin_oe_n(o_PIN_OE_N), .o_pin_wire(i_PIN_IN));

  initial begin
    I_CLK = 1'b0;
    forever #2.5 I_CLK = ~I_CLK;
  end

  // ==========================================================
  // tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge I_CLK);
    i_REG_ADDR <= a;
    i_REG_WDATA <= d;
    i_REG_WR <= 1'b1;
    @(posedge I_CLK);
    i_REG_WR <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge I_CLK);
    i_REG_ADDR <= a;
    i_REG_RD <= 1'b1;
    rq.push_back(e);
    @(posedge I_CLK);
    i_REG_RD <= 1'b0;
  endtask

  // on-chip answer is fixed at two cycles, off-chip follows timing
  task automatic acc(input logic w, input logic wd,
    input logic [7:0] idx, input logic [15:0] p, input logic [7:0] d,
    input logic [7:0] cyc, input logic c, input logic [7:0] e);
    int n;
    @(posedge I_CLK);
    i_ACC <= '{w, wd, idx, p, d};
    i_ACC_VALID <= 1'b1;
    aq.push_back({cyc, c, e});
    @(posedge I_CLK);
    i_ACC_VALID <= 1'b0;
    n = 0;
    while (o_ACC_DONE !== 1'b1 && n < 100) begin
      @(posedge I_CLK);
      n++;
    end
    if (n == 100) failures++;
  endtask

  function automatic logic [7:0] offc(input logic [7:0] c, t);
    return 8'h04 + 8'h02 * {6'h00, c[1:0]} + {6'h00, t[7:6]}
      + {4'h0, t[5:2]} + {6'h00, t[1:0]} + 8'h02;
  endfunction

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ==========================================================
  // result watcher
  always @(posedge I_CLK) begin
    cnt = i_ACC_VALID ? 0 : cnt + 1;
    if (o_ACC_DONE === 1'b1 && aq.size() > 0) begin
      x = aq.pop_front();
      chk(cnt[7:0], x[16:9]);
      if (x[8]) chk(o_ACC_RDATA, x[7:0]);
    end
    if (pend) chk(o_REG_RDATA, rq.pop_front());
    pend = i_REG_RD;
  end

  initial begin
    repeat (6000) @(posedge I_CLK);
    failures++;
    close_out();
  end

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(3));
    {I_NRST, i_REG_WR, i_REG_RD, i_ACC_VALID, pend, cnt} <= '0;
    {i_REG_ADDR, i_REG_WDATA, i_ACC, n_tests, failures} <= '0;
    i_LATCH_VAL <= 15'h60ff;
    i_LATCH_OE_N <= 15'h0000;
    d0 = 8'($urandom());
    d1 = 8'($urandom());
    d2 = 8'($urandom());
    repeat (5) @(posedge I_CLK);
    I_NRST <= 1'b1;
    rd(8'haa, 8'h00);
    rd(8'hab, 8'h03);
    rd(8'haf, 8'hff);
    rd(8'h5a, 8'h00);
    $display("test 1 done");
    acc(1'b1, 1'b1, 8'h00, 16'h1005, d0, 8'h02, 1'b0, 8'h00);
    acc(1'b0, 1'b0, 8'h05, 16'h0000, 8'h00, 8'h02, 1'b1, d0);
    wr(8'haa, 8'h10);
    acc(1'b0, 1'b0, 8'h05, 16'h0000, 8'h00, 8'h02, 1'b1, d0);
    acc(1'b1, 1'b1, 8'h00, 16'h0534, d1, 8'h02, 1'b0, 8'h00);
    rd(8'hac, 8'h00);
    $display("test 2 done");
    wr(8'hab, 8'h0f);
    acc(1'b1, 1'b0, 8'h34, 16'h0000, d2, 8'h21, 1'b0, 8'h00);
    wr(8'hab, 8'h0c);
    wr(8'haf, 8'h00);
    acc(1'b0, 1'b1, 8'h00, 16'h0034, 8'h00, 8'h06, 1'b1, d2);
    i_LATCH_VAL <= 15'h65ff;
    acc(1'b1, 1'b0, 8'h34, 16'h0000, d0, 8'h06, 1'b0, 8'h00);
    acc(1'b0, 1'b1, 8'h00, 16'h0534, 8'h00, 8'h06, 1'b1, d0);
    $display("test 3 done");
    wr(8'hab, 8'h04);
    acc(1'b0, 1'b0, 8'h34, 16'h0000, 8'h00, 8'h06, 1'b1, d0);
    acc(1'b0, 1'b1, 8'h00, 16'h0534, 8'h00, 8'h02, 1'b1, d1);
    acc(1'b0, 1'b1, 8'h00, 16'h1534, 8'h00, 8'h06, 1'b1, d0);
    wr(8'haa, 8'h05);
    acc(1'b0, 1'b0, 8'h34, 16'h0000, 8'h00, 8'h02, 1'b1, d1);
    $display("test 4 done");
    wr(8'haa, 8'h1a);
    wr(8'hab, 8'h08);
    acc(1'b1, 1'b0, 8'h22, 16'h0000, d2, 8'h06, 1'b0, 8'h00);
    acc(1'b0, 1'b1, 8'h00, 16'h1a22, 8'h00, 8'h06, 1'b1, d2);
    rd(8'hac, 8'h02);
    $display("test 5 done");
    for (int w = 0; w < 4; w++) begin
      cfg = 8'h0c | 8'(w);
      tim = 8'($urandom());
      wr(8'hab, cfg);
      wr(8'haf, tim);
      rd(8'hab, cfg);
      acc(1'b0, 1'b1, 8'h00, 16'h0534, 8'h00, offc(cfg, tim), 1'b1, d0);
    end
    $display("test 6 done");
    // disabled drivers let the pull-ups decide those address bits
    oe = 15'(12'($urandom()));
    d1 = 8'($urandom());
    acc(1'b1, 1'b1, 8'h00, {4'h0, oe[11:0] | 12'h534}, d1,
        offc(cfg, tim), 1'b0, 8'h00);
    i_LATCH_OE_N <= oe;
    acc(1'b0, 1'b1, 8'h00, 16'h0534, 8'h00, offc(cfg, tim), 1'b1, d1);
    i_LATCH_OE_N <= 15'h0000;
    $display("test 7 done");
    repeat (3) @(posedge I_CLK);
    close_out();
  end
endmodule // tb_top

`default_nettype wire
